// ### design/dac_align_pkg.sv
// Purpose: Shared constants and types for the converter word align and update block
// Assumes: 200 MHz MCLK, Avalon-MM register slave with 32-bit data
// Notes:   Offsets are byte addresses of aligned words
package dac_align_pkg;
  localparam int unsigned ADDR_W       = 4;
  localparam int unsigned WORD_W       = 12;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_LOW  = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_HIGH = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_OUT  = 4'hc;
  // Control field positions
  localparam int unsigned FMT_LSB      = 0;
  localparam int unsigned SRC_LSB      = 3;
  // Reset values
  localparam logic [7:0]        RST_BYTE = 8'h00;
  localparam logic [2:0]        RST_FMT  = 3'h0;
  localparam logic [WORD_W-1:0] RST_WORD = 12'h000;
  // Update source encodings
  typedef enum logic [1:0] {
    SRC_NONE = 2'b00,
    SRC_T3   = 2'b01,
    SRC_T4   = 2'b10,
    SRC_T2   = 2'b11
  } update_src_e;
  // Control register contents
  typedef struct packed {
    update_src_e src;
    logic [2:0]  word_justify_select;
  } ctrl_s;
  localparam ctrl_s RST_CTRL = '{src: SRC_NONE, word_justify_select: RST_FMT};
  // Timer overflow strobes
  typedef struct packed {
    logic t2;
    logic t3;
    logic t4;
  } tmr_ovf_s;
endpackage : dac_align_pkg

// ### design/dac_word_align_update_select.sv
// Purpose: Assemble the 12-bit converter word from two bytes and load it on a timer overflow
// Assumes: Timer strobes are one-cycle pulses synchronous to MCLK
// Notes:   Code 00 of the source field performs no update in this block
// Notes on behaviour
// RULE_01: Source code 10 loads the output only on a Timer 4 overflow.
// RULE_02: Source code 11 loads the output only on a Timer 2 overflow.
// RULE_03: Format 000 takes high byte bits 3:0 over the whole low byte.
// RULE_04: Format 001 takes high byte bits 4:0 over low byte bits 7:1.
// RULE_05: Format 010 takes high byte bits 5:0 over low byte bits 7:2.
// RULE_06: Format 011 takes high byte bits 6:0 over low byte bits 7:3.
// RULE_07: Formats 1xx take the whole high byte over low byte bits 7:4.
// RULE_08: Source code 01 loads the output only on a Timer 3 overflow.
// RULE_09: All twelve output bits load together in one cycle.
`timescale 1ns/10ps
module dac_word_align_update_select
  import dac_align_pkg::*;
(
  // Clock and reset
  input  wire logic                       MCLK,
  input  wire logic                       RST_B,
  // Avalon-MM slave
  input  wire logic [dac_align_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input  wire logic                       AVS_READ,
  input  wire logic                       AVS_WRITE,
  input  wire logic [31:0]                AVS_WRITEDATA,
  input  wire logic [3:0]                 AVS_BYTEENABLE,
  output logic [31:0]                     AVS_READDATA,
  output logic                            AVS_WAITREQUEST,
  // Timer overflow strobes
  input  dac_align_pkg::tmr_ovf_s         TMR_OVF,
  // Converter core
  output logic [dac_align_pkg::WORD_W-1:0] CONV_WORD,
  output logic                            CONV_LOAD
);
  import dac_align_pkg::*;

  // Register selected by the bus address; SEL_NONE covers every unmapped offset
  typedef enum logic [2:0] {
    SEL_LOW  = 3'b000,
    SEL_HIGH = 3'b001,
    SEL_CTRL = 3'b010,
    SEL_OUT  = 3'b011,
    SEL_NONE = 3'b100
  } reg_sel_e;

  // Data bytes and control fields written by software
  logic [7:0]        conv_word_low_byte_q, conv_word_low_byte_d;
  logic [7:0]        conv_word_high_byte_q, conv_word_high_byte_d;
  ctrl_s             ctrl_q, ctrl_d;
  // Bus handshake and read-back
  logic              ack_q, ack_d;
  logic [31:0]       rdata_q, rdata_d;
  reg_sel_e          sel;
  logic              access;
  logic              rd_take;
  logic              wr_done;
  // Converter output word and its load strobe
  logic [WORD_W-1:0] out_q, out_d;
  logic              load_q, load_d;
  logic [WORD_W-1:0] assembled;
  logic              trig;

  // Address decode, shared by the write path and the read-back path so that
  // both always agree on which offsets are mapped
  function automatic reg_sel_e decode_addr(input logic [ADDR_W-1:0] addr);
    reg_sel_e s;
    s = SEL_NONE;
    unique case (addr)
      OFS_LOW:  s = SEL_LOW;
      OFS_HIGH: s = SEL_HIGH;
      OFS_CTRL: s = SEL_CTRL;
      OFS_OUT:  s = SEL_OUT;
      default:  s = SEL_NONE;
    endcase
    return s;
  endfunction : decode_addr

  // Justify the two bytes into one word per the format field
  function automatic logic [WORD_W-1:0] justify(input logic [2:0] fmt,
                                                input logic [7:0] hi,
                                                input logic [7:0] lo);
    logic [WORD_W-1:0] w;
    w = RST_WORD;
    if (fmt[2]) begin
      // RULE_07 full high byte
      w = {hi, lo[7:4]};
    end else begin
      unique case (fmt[1:0])
        // RULE_03 nibble over byte
        2'b00: w = {hi[3:0], lo};
        // RULE_04 five over seven
        2'b01: w = {hi[4:0], lo[7:1]};
        // RULE_05 six over six
        2'b10: w = {hi[5:0], lo[7:2]};
        // RULE_06 seven over five
        2'b11: w = {hi[6:0], lo[7:3]};
      endcase
    end
    return w;
  endfunction : justify

  assign assembled = justify(ctrl_q.word_justify_select,
                             conv_word_high_byte_q, conv_word_low_byte_q);

  // Trigger select; only the chosen timer can update the output
  always_comb begin
    unique case (ctrl_q.src)
      // RULE_08 Timer 3 source
      SRC_T3:   trig = TMR_OVF.t3;
      // RULE_01 Timer 4 source
      SRC_T4:   trig = TMR_OVF.t4;
      // RULE_02 Timer 2 source
      SRC_T2:   trig = TMR_OVF.t2;
      SRC_NONE: trig = 1'b0;
    endcase
  end

  // Address decode for the access in flight
  assign sel = decode_addr(AVS_ADDRESS);

  // An access spends its first cycle with waitrequest high and completes in
  // its second; read data is captured in the first so it stands at the edge
  // where the master samples the wait dropped
  assign access  = AVS_READ || AVS_WRITE;
  assign rd_take = AVS_READ && !ack_q;
  // A write lands at that same completing edge, never while the wait is high
  assign wr_done = AVS_WRITE && ack_q;

  // Handshake next values; the acknowledge drops for a cycle after each
  // access, so a request still held at its completing edge is not taken twice
  always_comb begin
    ack_d   = 1'b0;
    rdata_d = rdata_q;
    if (access && !ack_q) begin
      ack_d = 1'b1;
    end
    // Read-back holds until the next read, so late sampling still sees it
    if (rd_take) begin
      unique case (sel)
        SEL_LOW:  rdata_d = {24'h000000, conv_word_low_byte_q};
        SEL_HIGH: rdata_d = {24'h000000, conv_word_high_byte_q};
        SEL_CTRL: rdata_d = {27'h0, ctrl_q};
        SEL_OUT:  rdata_d = {20'h00000, out_q};
        SEL_NONE: rdata_d = 32'h00000000; // Unmapped reads zero
      endcase
    end
  end

  // Register file next values; only byte lane 0 carries data, so a write
  // without it is acknowledged and dropped
  always_comb begin
    conv_word_low_byte_d  = conv_word_low_byte_q;
    conv_word_high_byte_d = conv_word_high_byte_q;
    ctrl_d                = ctrl_q;
    if (wr_done && AVS_BYTEENABLE[0]) begin
      unique case (sel)
        SEL_LOW:  conv_word_low_byte_d  = AVS_WRITEDATA[7:0];
        SEL_HIGH: conv_word_high_byte_d = AVS_WRITEDATA[7:0];
        SEL_CTRL: begin
          ctrl_d.word_justify_select = AVS_WRITEDATA[FMT_LSB +: 3];
          ctrl_d.src                 = update_src_e'(AVS_WRITEDATA[SRC_LSB +: 2]);
        end
        default:  ; // Output word is read-only; unmapped offsets ignored
      endcase
    end
  end

  // Output next values; all twelve bits move in one cycle so the converter
  // never sees old and new bits mixed. Limitation: bytes written between two
  // strobes are taken as they stand at the next strobe, so software should
  // finish both bytes before the selected timer overflows
  always_comb begin
    out_d  = out_q;
    load_d = 1'b0;
    // RULE_09 whole-word load
    if (trig) begin
      out_d  = assembled;
      load_d = 1'b1;
    end
  end

  // Register file state
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      conv_word_low_byte_q  <= RST_BYTE;
      conv_word_high_byte_q <= RST_BYTE;
      ctrl_q                <= RST_CTRL;
    end else begin
      conv_word_low_byte_q  <= conv_word_low_byte_d;
      conv_word_high_byte_q <= conv_word_high_byte_d;
      ctrl_q                <= ctrl_d;
    end
  end

  // Handshake state; read data clears on reset so nothing stale leaks out
  // of a read that was cut short by reset
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  // Output state
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      out_q  <= RST_WORD;
      load_q <= 1'b0;
    end else begin
      out_q  <= out_d;
      load_q <= load_d;
    end
  end

  // Wait is held until the access has been registered once
  assign AVS_WAITREQUEST = access && !ack_q;
  assign AVS_READDATA    = rdata_q;
  // Converter side comes straight from flip-flops
  assign CONV_WORD       = out_q;
  assign CONV_LOAD       = load_q;
endmodule : dac_word_align_update_select

// ### tb/dac_align_monitor.sv
// Purpose: Port assertions for the word align and update block
// Assumes: A write lands at the edge where waitrequest is sampled low
// Notes:   Shadows the byte and control registers to predict the word
`timescale 1ns/10ps
module dac_align_monitor
  import dac_align_pkg::*;
(
  // Clock, reset and bus
  input wire logic        MCLK, RST_B, AVS_WRITE, AVS_WAITREQUEST,
  input wire logic [3:0]  AVS_ADDRESS, AVS_BYTEENABLE,
  input wire logic [31:0] AVS_WRITEDATA,
  // Timers and converter
  input tmr_ovf_s         TMR_OVF,
  input wire logic [11:0] CONV_WORD,
  input wire logic        CONV_LOAD
);
  logic [7:0]  l_q, h_q;
  logic [4:0]  c_q;
  logic [11:0] w_d;
  logic        go;
  // Shadow copies follow completed writes only, so refused writes cannot mislead
  always_ff @(posedge MCLK or negedge RST_B)
    if (!RST_B) {l_q, h_q, c_q} <= '0;
    else if (AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0]) begin
      if (AVS_ADDRESS == OFS_LOW) l_q <= AVS_WRITEDATA[7:0];
      if (AVS_ADDRESS == OFS_HIGH) h_q <= AVS_WRITEDATA[7:0];
      if (AVS_ADDRESS == OFS_CTRL) c_q <= AVS_WRITEDATA[4:0];
    end
  // Expected word and trigger from the shadow state
  always_comb begin
    case (c_q[2:0])
      3'h0: w_d = {h_q[3:0], l_q};
      3'h1: w_d = {h_q[4:0], l_q[7:1]};
      3'h2: w_d = {h_q[5:0], l_q[7:2]};
      3'h3: w_d = {h_q[6:0], l_q[7:3]};
      default: w_d = {h_q, l_q[7:4]};
    endcase
    go = (c_q[4:3] == 2'h1 && TMR_OVF.t3) || (c_q[4:3] == 2'h2 && TMR_OVF.t4)
      || (c_q[4:3] == 2'h3 && TMR_OVF.t2);
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  chk_t4_load:
    assert property (c_q[4:3] == 2'h2 && TMR_OVF.t4 |=> CONV_LOAD) else $error("t4 load");
  chk_t2_load:
    assert property (c_q[4:3] == 2'h3 && TMR_OVF.t2 |=> CONV_LOAD) else $error("t2 load");
  chk_t3_load:
    assert property (c_q[4:3] == 2'h1 && TMR_OVF.t3 |=> CONV_LOAD) else $error("t3 load");
  chk_word_held:
    assert property (!go |=> !CONV_LOAD && $stable(CONV_WORD)) else $error("stray load");
  chk_fmt_nibble:
    assert property (go && c_q[2:0] == 3'h0 |=> CONV_WORD == $past(w_d)) else $error("fmt0");
  chk_fmt_five:
    assert property (go && c_q[2:0] == 3'h1 |=> CONV_WORD == $past(w_d)) else $error("fmt1");
  chk_fmt_six:
    assert property (go && c_q[2:0] == 3'h2 |=> CONV_WORD == $past(w_d)) else $error("fmt2");
  chk_fmt_seven:
    assert property (go && c_q[2:0] == 3'h3 |=> CONV_WORD == $past(w_d)) else $error("fmt3");
  chk_fmt_wide:
    assert property (go && c_q[2] |=> CONV_WORD == $past(w_d)) else $error("fmt1xx");
endmodule : dac_align_monitor
bind dac_word_align_update_select dac_align_monitor MON (.MCLK, .RST_B, .AVS_WRITE,
  .AVS_WAITREQUEST, .AVS_ADDRESS, .AVS_BYTEENABLE, .AVS_WRITEDATA, .TMR_OVF, .CONV_WORD,
  .CONV_LOAD);

// ### tb/tmr_ovf_model.sv
// Purpose: Timer overflow strobe source
// Assumes: The bench asks for a strobe for one cycle at a time
// Notes:   Registered, so strobes change just after the edge as real timers do
`timescale 1ns/10ps
module tmr_ovf_model
  import dac_align_pkg::*;
(
  input wire logic       MCLK, RST_B,
  input wire logic [2:0] REQ,
  output tmr_ovf_s       TMR_OVF
);
  // One-cycle overflow strobes
  always_ff @(posedge MCLK or negedge RST_B)
    if (!RST_B) TMR_OVF <= '0;
    else TMR_OVF <= tmr_ovf_s'(REQ);
endmodule : tmr_ovf_model

// ### tb/dac_word_align_update_select_tb.sv
// Purpose: Self-checking bench for the word align and update block
// Assumes: High byte a5 and low byte 3c throughout the format table
// Notes:   Each row also fires a timer that is not selected
`timescale 1ns/10ps
module dac_word_align_update_select_tb;
  import dac_align_pkg::*;
  typedef struct {logic [2:0] f; logic [1:0] s; logic [2:0] p; logic [11:0] w;} row_s;
  row_s rows [6] = '{'{3'h0, 2'h1, 3'h2, 12'h53c}, '{3'h1, 2'h2, 3'h1, 12'h29e},
    '{3'h2, 2'h3, 3'h4, 12'h94f}, '{3'h4, 2'h1, 3'h2, 12'ha53},
    '{3'h3, 2'h2, 3'h1, 12'h4a7}, '{3'h7, 2'h3, 3'h4, 12'ha53}};
  logic        MCLK = 0, RST_B = 0, AVS_READ = 0, AVS_WRITE = 0, AVS_WAITREQUEST, CONV_LOAD;
  logic [3:0]  AVS_ADDRESS = '0, AVS_BYTEENABLE = 4'h1;
  logic [31:0] AVS_WRITEDATA = '0, AVS_READDATA, rd;
  logic [11:0] CONV_WORD, prev = '0;
  logic [2:0]  req = '0;
  tmr_ovf_s    TMR_OVF;
  int          err_total = 0, checks_done = 0, cyc = 0, n_load = 0, n0 = 0;
  dac_word_align_update_select DUT (.MCLK, .RST_B, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
    .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .TMR_OVF, .CONV_WORD,
    .CONV_LOAD);
  tmr_ovf_model TMR (.MCLK, .RST_B, .REQ(req), .TMR_OVF);
  initial forever #2.5 MCLK = ~MCLK;
  task final_report;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask : chk
  // Request held until waitrequest is sampled low at a rising edge, released there
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge MCLK);
    {AVS_ADDRESS, AVS_WRITEDATA, AVS_WRITE, AVS_READ} <= {a, d, wr, !wr};
    do @(posedge MCLK); while (AVS_WAITREQUEST !== 1'b0);
    rd = AVS_READDATA;
    {AVS_WRITE, AVS_READ} <= 2'b00;
  endtask : bus
  task fire(input logic [2:0] p);
    @(posedge MCLK) req <= p;
    @(posedge MCLK) req <= '0;
    repeat (3) @(posedge MCLK);
  endtask : fire
  initial begin
    repeat (10) @(posedge MCLK);
    RST_B <= 1;
    bus(1, OFS_LOW, 32'h3c);
    bus(1, OFS_HIGH, 32'ha5);
    foreach (rows[i]) begin
      bus(1, OFS_CTRL, {27'h0, rows[i].s, rows[i].f});
      n0 = n_load;
      fire({rows[i].p[0], rows[i].p[2:1]});
      chk(CONV_WORD, prev);
      chk(n_load, n0);
      fire(rows[i].p);
      chk(CONV_WORD, rows[i].w);
      chk(n_load, n0 + 1);
      bus(0, OFS_OUT, 0);
      chk(rd, rows[i].w);
      prev = rows[i].w;
    end
    // Refused byte write must leave the word alone
    AVS_BYTEENABLE <= 4'h0;
    bus(1, OFS_LOW, 32'hff);
    AVS_BYTEENABLE <= 4'h1;
    fire(3'h4);
    chk(CONV_WORD, 12'ha53);
    // Source code 00 must ignore every timer
    bus(1, OFS_CTRL, 32'h3);
    n0 = n_load;
    fire(3'h7);
    chk(CONV_WORD, 12'ha53);
    chk(n_load, n0);
    bus(0, 4'h1, 32'h0);
    chk(rd, 32'h0);
    @(posedge MCLK) RST_B <= 0;
    repeat (2) @(posedge MCLK);
    chk(CONV_WORD, 12'h0);
    RST_B <= 1;
    bus(0, OFS_CTRL, 32'h0);
    chk(rd, 32'h0);
    bus(0, OFS_LOW, 32'h0);
    chk(rd, 32'h0);
    final_report;
  end
  // Load strobes counted at each rising edge, before the edge's own updates
  always @(posedge MCLK) n_load <= n_load + int'(CONV_LOAD);
  // Hang guard
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_total++;
      final_report;
    end
  end
endmodule : dac_word_align_update_select_tb
